// *** rtl/wdt_pkg.sv ***
// Constants, register map and types shared by the watchdog files.
// Assumes a 25 MHz system clock and a free-running 31 kHz oscillator pin.
package wdt_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int LF_OSC_FREQ_KHZ = 31;
    localparam int BASE_INTERVAL_MS = 1;
    // System clock cycles in one low-frequency oscillator period, rounded down.
    localparam int LF_PERIOD_CYCLES = CLK_FREQ_KHZ / LF_OSC_FREQ_KHZ;
    // Oscillator ticks in the base interval, exact: 31, not a power of two.
    localparam int BASE_TICKS_EXACT = LF_OSC_FREQ_KHZ * BASE_INTERVAL_MS;
    localparam int COUNT_W = 24;
    localparam logic [COUNT_W-1:0] BASE_RATIO = 24'h000020;

    // ========================================================================
    // Prescale field
    // ========================================================================
    localparam int SEL_W = 5;
    localparam logic [SEL_W-1:0] SEL_MAX = 5'h12;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h0B;

    // ========================================================================
    // Operating modes
    // ========================================================================
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SOFT = 2'h1,
        MODE_AWAKE_ONLY = 2'h2,
        MODE_ALWAYS = 2'h3
    } wdt_mode_e;

    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADR_WATCHDOG_CONTROL = 8'h00;
    localparam logic [ADR_W-1:0] ADR_CORE_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] ADR_IRQ_STATUS = 8'h08;
    localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_COUNT = 8'h10;

    localparam int CTL_W = 6;
    localparam int CTL_SWEN_BIT = 0;
    localparam int CTL_SEL_LSB = 1;
    localparam logic [CTL_W-1:0] CTL_RESET = 6'h16;

    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;

    localparam int IRQ_W = 2;
    localparam int IRQ_RESET_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;

endpackage

// *** rtl/lf_tick_gen.sv ***
// Turns the low-frequency oscillator pin into one-cycle tick pulses.
// Assumes the oscillator is far slower than clk_i.
`timescale 1ns/1ps
module lf_tick_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lf_osc_i,
    output logic tick_o
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic tick;
    } tick_state_s;

    tick_state_s q;
    tick_state_s d;

    // ========================================================================
    // Synchroniser and rising edge detect
    // ========================================================================
    always_comb begin
        d = q;
        d.sync1 = lf_osc_i;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        d.tick = q.sync2 & ~q.prev; // R1
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule // lf_tick_gen

// *** rtl/watchdog_timer_block.sv ***
// Watchdog timer with Wishbone registers, sleep wake-up and status flags.
// Assumes CPU event inputs come from logic on clk_i and the oscillator is a pin.
//
// Notes on behaviour
// R1: Counter advances on low-frequency oscillator ticks.
// R2: Base interval is one millisecond nominal.
// R3: Timeout while awake requests device reset.
// R4: Two-bit mode; code 00 always off.
// R5: Mode 11 active always, even sleeping.
// R6: Mode 10 active awake, off sleeping.
// R7: Mode 01 follows software enable bit.
// R8: Prescale selects 1 ms to 256 s.
// R9: Reset loads two-second prescale selection.
// R10: Counter cleared on all listed conditions.
// R11: Sleep entry clears, then counting resumes.
// R12: Wake clears; held clear during start-up timer.
// R13: Timeout while sleeping wakes, no reset.
// R14: Timeout updates timeout and power-down flags; the code clears only to_n and leaves pd_n unchanged.
// R15: Prescale decode doubles; reserved codes minimum.
// R16: Software enable ignored outside mode 01.
// R17: Sleep clears power-down, sets timeout flag.
// R18: Clears land in the tick domain safely.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module watchdog_timer_block
    import wdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic low_freq_internal_osc_i,
    input wire logic [1:0] watchdog_mode_cfg_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic sleep_instr_i,
    input wire logic wake_event_i,
    input wire logic osc_fail_i,
    input wire logic osc_startup_timer_i,
    output logic device_reset_o,
    output logic wake_o,
    output logic sleeping_o,
    output logic timeout_flag_n_o,
    output logic powerdown_flag_n_o,
    output logic irq_o
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic to_n;
        logic pd_n;
        logic sleeping;
        logic [COUNT_W-1:0] count;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic ack;
        logic [31:0] dat;
        logic reset_pulse;
        logic wake_pulse;
    } wdt_state_s;

    wdt_state_s q;
    wdt_state_s d;

    logic tick;
    wdt_mode_e mode;
    logic [SEL_W-1:0] sel;
    logic swen;
    logic active;
    logic clear;
    logic [COUNT_W-1:0] ratio_m1;
    logic expire;
    logic req;
    logic wr;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_w1c;

    // ========================================================================
    // Oscillator tick
    // ========================================================================
    lf_tick_gen lf_tick_gen_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lf_osc_i(low_freq_internal_osc_i),
        .tick_o(tick)
    );

    // ========================================================================
    // Mode, enable and timeout decode
    // ========================================================================
    assign mode = wdt_mode_e'(watchdog_mode_cfg_i);
    assign sel = q.ctl[CTL_SEL_LSB +: SEL_W];
    assign swen = q.ctl[CTL_SWEN_BIT];

    always_comb begin
        case (mode)
            MODE_ALWAYS: active = 1'b1; // R5
            MODE_AWAKE_ONLY: active = ~q.sleeping; // R6
            MODE_SOFT: active = swen; // R7 R16
            MODE_OFF: active = 1'b0; // R4
            default: active = 1'b0;
        endcase
    end

    always_comb begin
        if (sel <= SEL_MAX) begin
            ratio_m1 = (BASE_RATIO << sel) - BASE_RATIO / BASE_RATIO; // R8 R15 R2
        end else begin
            ratio_m1 = BASE_RATIO - 24'h000001; // R15
        end
    end

    // Every clear source is on clk_i, as is the tick, so none can be missed.
    assign clear = watchdog_clear_instr_i | sleep_instr_i | wake_event_i | osc_fail_i
        | osc_startup_timer_i | ~active; // R10 R11 R12 R18
    assign expire = tick & active & ~clear & (q.count == ratio_m1); // R3 R13

    // ========================================================================
    // Bus decode
    // ========================================================================
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & q.ack & wb_sel_i[0];
    assign irq_set = {expire & q.sleeping, expire & ~q.sleeping};
    assign irq_w1c = (wr && wb_adr_i == ADR_IRQ_STATUS) ? wb_dat_i[IRQ_W-1:0] : '0;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        d = q;
        d.reset_pulse = 1'b0;
        d.wake_pulse = 1'b0;

        // Counter.
        if (clear) begin
            d.count = '0; // R10
        end else if (expire) begin
            d.count = '0;
        end else if (tick) begin
            d.count = q.count + 24'h000001; // R1
        end

        // Sleep entry and exit.
        if (sleep_instr_i && !q.sleeping) begin
            d.sleeping = 1'b1; // R11
            d.pd_n = 1'b0; // R17
            d.to_n = 1'b1; // R17
        end
        if (wake_event_i) begin
            d.sleeping = 1'b0; // R12
        end
        if (watchdog_clear_instr_i) begin
            d.to_n = 1'b1;
            d.pd_n = 1'b1;
        end

        // Timeout.
        if (expire) begin
            d.to_n = 1'b0; // R14
            if (q.sleeping) begin
                d.sleeping = 1'b0; // R13
                d.wake_pulse = 1'b1; // R13
            end else begin
                d.reset_pulse = 1'b1; // R3
            end
        end

        // Interrupt status: a new event wins over a write-one clear.
        d.irq_status = (q.irq_status & ~irq_w1c) | irq_set;

        // Register writes take effect on the acknowledge edge.
        if (wr) begin
            case (wb_adr_i)
                ADR_WATCHDOG_CONTROL: d.ctl = wb_dat_i[CTL_W-1:0];
                ADR_IRQ_MASK: d.irq_mask = wb_dat_i[IRQ_W-1:0];
                default: d.ctl = q.ctl;
            endcase
        end

        // Acknowledge one cycle after the request, read data with it.
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            case (wb_adr_i)
                ADR_WATCHDOG_CONTROL: d.dat = {26'h0000000, q.ctl};
                ADR_CORE_STATUS: begin
                    d.dat = '0;
                    d.dat[STAT_TO_BIT] = q.to_n;
                    d.dat[STAT_PD_BIT] = q.pd_n;
                end
                ADR_IRQ_STATUS: d.dat = {30'h00000000, q.irq_status};
                ADR_IRQ_MASK: d.dat = {30'h00000000, q.irq_mask};
                ADR_COUNT: d.dat = {8'h00, q.count};
                default: d.dat = '0;
            endcase
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ctl <= CTL_RESET; // R9
            q.to_n <= 1'b1;
            q.pd_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign device_reset_o = q.reset_pulse;
    assign wake_o = q.wake_pulse;
    assign sleeping_o = q.sleeping;
    assign timeout_flag_n_o = q.to_n;
    assign powerdown_flag_n_o = q.pd_n;
    assign irq_o = |(q.irq_status & q.irq_mask);

endmodule // watchdog_timer_block

// *** sim/wdt_props.sv ***
// Concurrent checks on the ports of the watchdog block.
// Assumes one clock, clk_i, and a synchronous active-high reset, rst_i.
`timescale 1ns/1ps
module wdt_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] watchdog_mode_cfg_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic sleep_instr_i,
    input wire logic osc_fail_i,
    input wire logic device_reset_o,
    input wire logic wake_o,
    input wire logic sleeping_o,
    input wire logic timeout_flag_n_o,
    input wire logic powerdown_flag_n_o
);
    // ========================================================================
    // Port relations
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_enter;
        sleep_instr_i && !sleeping_o;
    endsequence
    a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_sleep_entry_flags: assert property (s_enter |=> sleeping_o && !powerdown_flag_n_o
        && timeout_flag_n_o && !device_reset_o && !wake_o) else $error("sleep entry wrong");
    a_clear_stops_fire: assert property ((watchdog_clear_instr_i || osc_fail_i)
        |=> !device_reset_o && !wake_o) else $error("fired after clear");
    a_off_mode_quiet: assert property (watchdog_mode_cfg_i == 2'h0
        |=> !device_reset_o && !wake_o) else $error("fired while off");
    a_sleep_off_mode: assert property (sleeping_o && watchdog_mode_cfg_i == 2'h2
        |=> !wake_o) else $error("woke in awake-only mode");
    a_reset_when_awake: assert property (device_reset_o |-> !$past(sleeping_o)
        && !timeout_flag_n_o) else $error("reset while asleep");
    a_wake_when_asleep: assert property (wake_o |-> $past(sleeping_o) && !sleeping_o
        && !timeout_flag_n_o) else $error("wake wrong");
    a_reset_pulse_single: assert property (device_reset_o |=> !device_reset_o)
        else $error("reset pulse too long");
endmodule // wdt_props
bind watchdog_timer_block wdt_props wdt_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .watchdog_mode_cfg_i(watchdog_mode_cfg_i), .watchdog_clear_instr_i(watchdog_clear_instr_i),
    .sleep_instr_i(sleep_instr_i), .osc_fail_i(osc_fail_i), .device_reset_o(device_reset_o),
    .wake_o(wake_o), .sleeping_o(sleeping_o), .timeout_flag_n_o(timeout_flag_n_o),
    .powerdown_flag_n_o(powerdown_flag_n_o));

// *** sim/tb_watchdog_timer_block.sv ***
// Self-checking bench for the watchdog block.
// Assumes the oscillator pin may be driven fast: one tick every 16 clocks.
`timescale 1ns/1ps
module tb_watchdog_timer_block;
    import wdt_pkg::*;
    // ========================================================================
    // Stimulus and checks
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, osc = 1'b0, clr = 1'b0;
    logic slp = 1'b0, wev = 1'b0, ofail = 1'b0, osc_startup_timer = 1'b0;
    logic [1:0] mode = 2'h2;
    logic [ADR_W-1:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, dev_rst, wake, sleeping, to_n, pd_n, irq;
    int errors = 0, n_compared = 0, n_rst = 0, n_wake = 0;
    watchdog_timer_block watchdog_timer_block_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .low_freq_internal_osc_i(osc),
        .watchdog_mode_cfg_i(mode), .watchdog_clear_instr_i(clr), .sleep_instr_i(slp),
        .wake_event_i(wev), .osc_fail_i(ofail), .osc_startup_timer_i(osc_startup_timer),
        .device_reset_o(dev_rst), .wake_o(wake), .sleeping_o(sleeping),
        .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n), .irq_o(irq));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always begin
        repeat (8) @(posedge clk_i);
        osc <= ~osc;
    end
    always @(posedge clk_i) begin
        n_rst <= n_rst + (dev_rst === 1'b1);
        n_wake <= n_wake + (wake === 1'b1);
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        chk1("ack", 1'b1, n < 50);
    endtask
    task automatic idle(input int t);
        repeat (t * 16) @(posedge clk_i);
    endtask
    task automatic pulse_clr;
        @(posedge clk_i) clr <= 1'b1;
        @(posedge clk_i) clr <= 1'b0;
    endtask
    task automatic t_regs;
        wb(0, ADR_WATCHDOG_CONTROL, 0);
        chk("control", 32'h16, rdat);
        wb(0, ADR_CORE_STATUS, 0);
        chk("status", 32'h18, rdat);
        wb(1, 8'h40, 32'hFF);
        wb(0, 8'h40, 0);
        chk("unmapped", 32'h0, rdat);
        wb(1, ADR_WATCHDOG_CONTROL, 32'hFF);
        wb(0, ADR_WATCHDOG_CONTROL, 0);
        chk("control rw", 32'h3F, rdat);
        $display("t_regs done");
    endtask
    task automatic t_period(input logic [1:0] m, input logic [4:0] sel, input int ticks);
        int n;
        n = 0;
        mode <= m;
        wb(1, ADR_WATCHDOG_CONTROL, {26'h0, sel, 1'b1});
        pulse_clr();
        while (dev_rst !== 1'b1 && n < ticks * 20) begin
            @(posedge clk_i);
            n++;
        end
        chk1("period", 1'b1, n > ticks * 16 - 24 && n < ticks * 16 + 24);
        @(posedge clk_i);
        chk1("timeout flag", 1'b0, to_n);
        $display("t_period done");
    endtask
    task automatic t_irq;
        mode <= 2'h0;
        wb(0, ADR_IRQ_STATUS, 0);
        chk("irq status", 32'h1, rdat);
        chk1("irq masked", 1'b0, irq);
        wb(1, ADR_IRQ_MASK, 32'h3);
        @(posedge clk_i);
        chk1("irq on", 1'b1, irq);
        wb(1, ADR_IRQ_STATUS, 32'h1);
        @(posedge clk_i);
        chk1("irq cleared", 1'b0, irq);
        $display("t_irq done");
    endtask
    task automatic t_quiet;
        int base;
        for (int k = 0; k < 5; k++) begin
            base = n_rst;
            mode <= (k == 0) ? 2'h0 : ((k == 1) ? 2'h1 : 2'h3);
            wb(1, ADR_WATCHDOG_CONTROL, {31'h0, k == 0});
            pulse_clr();
            ofail <= (k == 3);
            osc_startup_timer <= (k == 4);
            idle(20);
            clr <= (k == 2);
            idle(20);
            ofail <= 1'b0;
            osc_startup_timer <= 1'b0;
            chk("no reset", base, n_rst);
        end
        $display("t_quiet done");
    endtask
    task automatic t_sleep(input logic [1:0] m);
        int n, base, wbase;
        n = 0;
        base = n_rst;
        wbase = n_wake;
        mode <= m;
        pulse_clr();
        idle(10);
        @(posedge clk_i) slp <= 1'b1;
        @(posedge clk_i) slp <= 1'b0;
        @(posedge clk_i);
        chk1("pd flag", 1'b0, pd_n);
        chk1("to flag", 1'b1, to_n);
        while (wake !== 1'b1 && n < 700) begin
            @(posedge clk_i);
            n++;
        end
        chk1("sleep wake", m == 2'h3, n > 488 && n < 536);
        chk("no reset", base, n_rst);
        wev <= 1'b1;
        @(posedge clk_i) wev <= 1'b0;
        @(posedge clk_i);
        chk1("awake", 1'b0, sleeping);
        chk1("to after wake", m != 2'h3, to_n);
        chk("wake pulses", {31'h0, m == 2'h3}, n_wake - wbase);
        $display("t_sleep done");
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_period(2'h2, 5'h00, 32);
        t_period(2'h1, 5'h01, 64);
        t_period(2'h3, 5'h13, 32);
        t_irq();
        t_quiet();
        t_sleep(2'h3);
        t_sleep(2'h2);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end
endmodule // tb_watchdog_timer_block
